// file: gsl_pkg.sv
// How it works
// - gauge bit cycles toward host last 190 to 250 us, nominal 205 us
// - gauge sends a one as a low pulse of 32 to 50 us
// - gauge sends a zero as a low pulse of 80 to 145 us
// - gauge reply starts 190 to 950 us after a read request ends
// - commands arrive over single wire or two wire, both reach storage except a two-wire access in the cycle of a single-wire write
package gsl_pkg;

  // ************************************************************
  // clock and widths
  // ************************************************************
  localparam real CLK_MHZ = 25.0;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WR_BIT = 7;
  localparam int BIT_IDX_W = 4;
  localparam logic [BIT_IDX_W-1:0] LAST_BIT = 4'h7;

  // least time, rounded up to whole cycles
  function automatic int cyc_ceil(input real us);
    return int'($ceil(us * CLK_MHZ));
  endfunction

  // longest time, rounded down to whole cycles
  function automatic int cyc_floor(input real us);
    return int'($floor(us * CLK_MHZ));
  endfunction

  // ************************************************************
  // times in microseconds
  // ************************************************************
  localparam real HOST_ONE_MAX_US = 50.0;
  localparam real HOST_ZERO_MIN_US = 86.0;
  localparam real SPLIT_US = 68.0;
  localparam real BREAK_MIN_US = 190.0;
  localparam real BREAK_RECOVERY_US = 40.0;
  localparam real GAUGE_ONE_US = 40.0;
  localparam real GAUGE_ZERO_US = 110.0;
  localparam real GAUGE_CYCLE_US = 205.0;
  localparam real GAUGE_REPLY_US = 300.0;
  localparam real GAUGE_ONE_MIN_US = 32.0;
  localparam real GAUGE_ONE_MAX_US = 50.0;
  localparam real GAUGE_ZERO_MIN_US = 80.0;
  localparam real GAUGE_ZERO_MAX_US = 145.0;
  localparam real GAUGE_CYCLE_MIN_US = 190.0;
  localparam real GAUGE_CYCLE_MAX_US = 250.0;
  localparam real REPLY_MIN_US = 190.0;
  localparam real REPLY_MAX_US = 950.0;

  // ************************************************************
  // counts in clock cycles
  // ************************************************************
  localparam int SPLIT_CYC = cyc_floor(SPLIT_US);
  localparam int BREAK_CYC = cyc_ceil(BREAK_MIN_US);
  localparam int ONE_CYC = cyc_ceil(GAUGE_ONE_US);
  localparam int ZERO_CYC = cyc_ceil(GAUGE_ZERO_US);
  localparam int CYCLE_CYC = cyc_ceil(GAUGE_CYCLE_US);
  localparam int REPLY_CYC = cyc_ceil(GAUGE_REPLY_US);
  localparam int ONE_MIN_CYC = cyc_ceil(GAUGE_ONE_MIN_US);
  localparam int ONE_MAX_CYC = cyc_floor(GAUGE_ONE_MAX_US);
  localparam int ZERO_MIN_CYC = cyc_ceil(GAUGE_ZERO_MIN_US);
  localparam int ZERO_MAX_CYC = cyc_floor(GAUGE_ZERO_MAX_US);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_ADDR,
    ST_WDATA,
    ST_WAIT,
    ST_TX_LOW,
    ST_TX_HIGH
  } gsl_state_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gsl_tw_cmd_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic low;
    logic done;
    logic bit_val;
    logic brk;
  } gsl_meter_t;

  typedef struct packed {
    gsl_state_t st;
    logic [DATA_W-1:0] sr;
    logic [BIT_IDX_W-1:0] nbits;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [CNT_W-1:0] timer;
    logic oe;
    logic line_lvl;
    logic wr_pend;
    logic tw_ack;
    logic [DATA_W-1:0] tw_rdata;
    logic busy;
  } gsl_core_t;

endpackage

// file: gsl_pulse_meter.sv
`timescale 1ns/1ps
module gsl_pulse_meter import gsl_pkg::*; #(
  parameter logic [CNT_W-1:0] P_BREAK = CNT_W'(BREAK_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_line,
  input wire logic i_ignore,
  output logic o_done,
  output logic o_bit,
  output logic o_brk
);

  localparam logic [CNT_W-1:0] SPLIT = CNT_W'(SPLIT_CYC);

  gsl_meter_t m;
  gsl_meter_t next_m;

  // measure each low pulse, classify it on release unless it reached the break length
  always_comb begin
    next_m = m;
    next_m.done = 1'b0;
    next_m.brk = 1'b0;
    if (i_ignore) begin
      next_m.cnt = '0;
      next_m.low = 1'b0;
    end else if (!i_line) begin
      next_m.low = 1'b1;
      if (m.cnt != P_BREAK) begin
        next_m.cnt = m.cnt + CNT_W'(1);
      end
      if (m.cnt == P_BREAK - CNT_W'(1)) begin
        next_m.brk = 1'b1;
      end
    end else if (m.low) begin
      next_m.low = 1'b0;
      next_m.cnt = '0;
      if (m.cnt != P_BREAK) begin
        next_m.done = 1'b1;
        next_m.bit_val = (m.cnt < SPLIT);
      end
    end
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      m <= '0;
    end else begin
      m <= next_m;
    end
  end

  assign o_done = m.done;
  assign o_bit = m.bit_val;
  assign o_brk = m.brk;

endmodule // gsl_pulse_meter

// file: gsl_link.sv
`timescale 1ns/1ps
module gsl_link import gsl_pkg::*; #(
  parameter int DEPTH = 128,
  parameter logic [CNT_W-1:0] P_BREAK = CNT_W'(BREAK_CYC),
  parameter logic [CNT_W-1:0] P_CYCLE = CNT_W'(CYCLE_CYC),
  parameter logic [CNT_W-1:0] P_REPLY = CNT_W'(REPLY_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_line_in,
  output logic o_line_out,
  output logic o_line_oe,
  input wire logic i_tw_req,
  input wire gsl_tw_cmd_t i_tw_cmd,
  output logic o_tw_ack,
  output logic [DATA_W-1:0] o_tw_rdata,
  output logic o_sw_wr,
  output logic [ADDR_W-1:0] o_sw_addr,
  output logic [DATA_W-1:0] o_sw_wdata,
  output logic o_busy
);

  localparam logic [CNT_W-1:0] P_ONE = CNT_W'(ONE_CYC);
  localparam logic [CNT_W-1:0] P_ZERO = CNT_W'(ZERO_CYC);

  // ************************************************************
  // state and storage
  // ************************************************************
  gsl_core_t s;
  gsl_core_t next_s;
  logic [DATA_W-1:0] mem [DEPTH];
  logic pm_done;
  logic pm_bit;
  logic pm_brk;
  logic [DATA_W-1:0] rx_byte;
  logic tw_write;

  // receiver ignores the line while the gauge pulls it
  gsl_pulse_meter #(
    .P_BREAK(P_BREAK)
  ) u_meter (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_line(i_line_in),
    .i_ignore(s.oe),
    .o_done(pm_done),
    .o_bit(pm_bit),
    .o_brk(pm_brk)
  );

  // bits arrive least significant first
  assign rx_byte = {pm_bit, s.sr[DATA_W-1:1]};
  // two-wire write yields to a single-wire write
  assign tw_write = i_tw_req & i_tw_cmd.wr & ~s.wr_pend;

  // ************************************************************
  // protocol sequencer
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.wr_pend = 1'b0;
    next_s.timer = s.timer + CNT_W'(1);
    next_s.tw_ack = i_tw_req & ~s.wr_pend;
    if (next_s.tw_ack) begin
      next_s.tw_rdata = mem[i_tw_cmd.addr];
    end
    case (s.st)
      ST_ADDR: begin
        if (pm_done) begin
          next_s.sr = rx_byte;
          next_s.nbits = s.nbits + BIT_IDX_W'(1);
          if (s.nbits == LAST_BIT) begin
            next_s.nbits = '0;
            next_s.addr = rx_byte[ADDR_W-1:0];
            if (rx_byte[WR_BIT]) begin
              next_s.st = ST_WDATA;
            end else begin
              next_s.st = ST_WAIT;
              next_s.timer = '0;
            end
          end
        end
      end
      ST_WDATA: begin
        if (pm_done) begin
          next_s.sr = rx_byte;
          next_s.nbits = s.nbits + BIT_IDX_W'(1);
          if (s.nbits == LAST_BIT) begin
            next_s.nbits = '0;
            next_s.wdata = rx_byte;
            next_s.wr_pend = 1'b1;
            next_s.st = ST_ADDR;
          end
        end
      end
      ST_WAIT: begin
        if (s.timer == P_REPLY - CNT_W'(1)) begin
          next_s.st = ST_TX_LOW;
          next_s.sr = mem[s.addr];
          next_s.timer = '0;
          next_s.nbits = '0;
          next_s.oe = 1'b1;
        end
      end
      ST_TX_LOW: begin
        if (s.timer == (s.sr[0] ? P_ONE : P_ZERO) - CNT_W'(1)) begin
          next_s.oe = 1'b0;
          next_s.st = ST_TX_HIGH;
        end
      end
      ST_TX_HIGH: begin
        if (s.timer == P_CYCLE - CNT_W'(1)) begin
          next_s.timer = '0;
          next_s.sr = s.sr >> 1;
          next_s.nbits = s.nbits + BIT_IDX_W'(1);
          if (s.nbits == LAST_BIT) begin
            next_s.nbits = '0;
            next_s.st = ST_ADDR;
          end else begin
            next_s.st = ST_TX_LOW;
            next_s.oe = 1'b1;
          end
        end
      end
      default: begin
        next_s = '0;
      end
    endcase
    if (pm_brk) begin
      next_s.st = ST_ADDR;
      next_s.nbits = '0;
      next_s.oe = 1'b0;
    end
    next_s.line_lvl = 1'b0;
    // busy kept in a flop so the output is registered
    next_s.busy = (next_s.st != ST_ADDR) | (next_s.nbits != '0);
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage writes, single wire first
  always_ff @(posedge i_core_clk) begin
    if (s.wr_pend) begin
      mem[s.addr] <= s.wdata;
    end else if (tw_write) begin
      mem[i_tw_cmd.addr] <= i_tw_cmd.wdata;
    end
  end

  // outputs straight from the state register
  assign o_line_out = s.line_lvl;
  assign o_line_oe = s.oe;
  assign o_tw_ack = s.tw_ack;
  assign o_tw_rdata = s.tw_rdata;
  assign o_sw_wr = s.wr_pend;
  assign o_sw_addr = s.addr;
  assign o_sw_wdata = s.wdata;
  assign o_busy = s.busy;

  // ************************************************************
  // checks
  // ************************************************************
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] wait_cnt;
  logic oe_q;

  // helper counters for pulse, period and reply wait
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt <= '0;
      per_cnt <= '0;
      wait_cnt <= '0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= s.oe;
      low_cnt <= s.oe ? low_cnt + CNT_W'(1) : '0;
      per_cnt <= (s.oe && !oe_q) ? CNT_W'(1) : per_cnt + CNT_W'(1);
      wait_cnt <= (s.st == ST_WAIT) ? wait_cnt + CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_one_width: assert property ($fell(s.oe) && s.sr[0] |-> low_cnt == P_ONE)
    else $error("one pulse width wrong");
  chk_zero_width: assert property ($fell(s.oe) && !s.sr[0] |-> low_cnt == P_ZERO)
    else $error("zero pulse width wrong");
  chk_one_range: assert property ($fell(s.oe) |-> low_cnt >= CNT_W'(ONE_MIN_CYC))
    else $error("pulse shorter than least one width");
  chk_zero_range: assert property ($fell(s.oe) |-> low_cnt <= CNT_W'(ZERO_MAX_CYC))
    else $error("pulse longer than longest zero width");
  chk_bit_cycle: assert property ($rose(s.oe) && s.nbits != '0 |-> per_cnt == P_CYCLE)
    else $error("bit cycle length wrong");
  chk_reply_delay: assert property ($rose(s.oe) && s.nbits == '0 |-> wait_cnt == P_REPLY)
    else $error("reply delay wrong");
  chk_never_high: assert property (!o_line_out)
    else $error("line driven high");
  chk_oe_in_low: assert property (o_line_oe |-> s.st == ST_TX_LOW)
    else $error("line pulled outside a low pulse");
  chk_break_resync: assert property (pm_brk |=> s.st == ST_ADDR && s.nbits == '0 && !s.oe)
    else $error("break did not resync");
  chk_sw_write: assert property (
      s.st == ST_WDATA && pm_done && s.nbits == LAST_BIT && !pm_brk
      |=> o_sw_wr ##1 !o_sw_wr)
    else $error("single-wire write not one pulse");
  chk_tw_ack: assert property (i_tw_req && !s.wr_pend |=> o_tw_ack)
    else $error("two-wire access not acknowledged");

  cov_read_reply: cover property (s.st == ST_TX_HIGH && s.nbits == LAST_BIT
      && s.timer == P_CYCLE - CNT_W'(1));
  cov_sw_write: cover property (o_sw_wr);
  cov_break: cover property (pm_brk);
  cov_tw_write: cover property (tw_write);

endmodule // gsl_link

// file: gsl_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// host side of the single-wire link
// ************************************************************
module gsl_host_model import gsl_pkg::*; #(
  parameter int HOST_CYC = 2200,
  parameter int BRK_CYC = BREAK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_line,
  input wire logic i_start,
  input wire logic i_brk,
  input wire logic i_rd,
  input wire logic [4:0] i_nbits,
  input wire logic [15:0] i_word,
  output logic o_pull,
  output logic o_idle,
  output logic o_rx_valid,
  output logic [DATA_W-1:0] o_rx_byte
);
  int w;
  int n;
  logic [15:0] word_l;
  logic [DATA_W-1:0] rx;

  task automatic pulse(input int lo, input int cyc);
    o_pull <= 1'b1;
    repeat (lo) @(posedge i_core_clk);
    o_pull <= 1'b0;
    repeat (cyc - lo) @(posedge i_core_clk);
  endtask

  // released line at start, then one request from the bench at a time
  initial begin
    o_pull = 1'b0;
    o_idle = 1'b1;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    forever begin
      @(posedge i_core_clk);
      if (i_start) begin
        o_idle <= 1'b0;
        word_l = i_word;
        n = int'(i_nbits);
        // break of 190 us, then 40 us recovery
        if (i_brk) pulse(BRK_CYC, BRK_CYC + 1000);
        // pulse widths, cycle length from HOST_CYC
        for (int i = 0; i < n; i++) pulse(word_l[i] ? 25 : 2150, HOST_CYC);
        if (i_rd) begin
          for (int b = 0; b < DATA_W; b++) begin
            w = 0;
            for (int t = 0; t < 30000 && i_line; t++) @(posedge i_core_clk);
            while (!i_line && w < 30000) begin
              @(posedge i_core_clk);
              w++;
            end
            rx[b] = (w < 1625);
          end
          o_rx_byte <= rx;
          o_rx_valid <= 1'b1;
          @(posedge i_core_clk);
          o_rx_valid <= 1'b0;
        end
        o_idle <= 1'b1;
      end
    end
  end
endmodule // gsl_host_model

// file: gsl_link_tb.sv
`timescale 1ns/1ps
// ************************************************************
// link bench
// ************************************************************
module gsl_link_tb import gsl_pkg::*;;
  localparam logic [CNT_W-1:0] BRK_P = 16'h0960;
  localparam logic [CNT_W-1:0] CYC_P = 16'h0af0;
  localparam logic [CNT_W-1:0] RPL_P = 16'h12c0; // 192 us, above the least reply delay
  localparam int TW_GAP = cyc_ceil(66.0);
  logic clk, rstn, req, oe, lo, ack, sw_wr, busy;
  logic st, brk, rd, pull, idle, rxv;
  logic oe_d = 1'b0;
  logic armed = 1'b0;
  gsl_tw_cmd_t cmd;
  logic [DATA_W-1:0] rdata, sw_wd, rxb, d, e;
  logic [ADDR_W-1:0] sw_ad, a, b;
  logic [4:0] nb;
  logic [15:0] word;
  logic [15:0] exp_q[$];
  int error_cnt, samples_checked, whi, wgap, quiet;
  wire logic line = ~oe & ~pull;

  gsl_link #(.P_BREAK(BRK_P), .P_CYCLE(CYC_P), .P_REPLY(RPL_P)) uut (.i_core_clk(clk),
    .i_resetn(rstn),
    .i_line_in(line), .o_line_out(lo), .o_line_oe(oe), .i_tw_req(req), .i_tw_cmd(cmd),
    .o_tw_ack(ack), .o_tw_rdata(rdata), .o_sw_wr(sw_wr), .o_sw_addr(sw_ad),
    .o_sw_wdata(sw_wd), .o_busy(busy));
  gsl_host_model host (.i_core_clk(clk), .i_line(line), .i_start(st), .i_brk(brk),
    .i_rd(rd), .i_nbits(nb), .i_word(word), .o_pull(pull), .o_idle(idle),
    .o_rx_valid(rxv), .o_rx_byte(rxb));

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // report and compare helpers
  task automatic bad(input logic [31:0] got, input logic [31:0] exp);
    error_cnt++;
    $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) bad(got, exp);
  endtask
  task automatic rng(input int got, input int lo_b, input int hi_b);
    samples_checked++;
    if (got < lo_b || got > hi_b) bad(32'(got), 32'(lo_b));
  endtask
  task automatic pop(input logic [15:0] got);
    if (exp_q.size() == 0) bad(32'(got), 32'h0);
    else cmp(32'(got), 32'(exp_q.pop_front()));
  endtask
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one host request, bounded wait for idle
  task automatic host_op(input logic k, input logic [4:0] n, input logic [15:0] w,
    input logic r);
    @(posedge clk);
    st <= 1'b1;
    brk <= k;
    nb <= n;
    word <= w;
    rd <= r;
    @(posedge clk);
    st <= 1'b0;
    repeat (2) @(posedge clk);
    for (int t = 0; t < 60000 && !idle; t++) @(posedge clk);
    if (idle !== 1'b1) bad(32'(idle), 32'h1);
  endtask

  // one two-wire access, single-cycle request
  task automatic tw(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
    // bus idle gap before each access
    repeat (TW_GAP) @(posedge clk);
    req <= 1'b1;
    cmd <= '{wr: w, addr: ad, wdata: dt};
    @(posedge clk);
    req <= 1'b0;
    for (int t = 0; t < 4 && ack !== 1'b1; t++) @(posedge clk);
    if (ack !== 1'b1) bad(32'(ack), 32'h1);
  endtask

  // results against the oldest note
  always @(posedge clk) begin
    if (sw_wr === 1'b1) pop({1'b0, sw_ad, sw_wd});
    if (ack === 1'b1 && cmd.wr === 1'b0) pop({8'h00, rdata});
    if (rxv === 1'b1) pop({8'h00, rxb});
  end

  // reply timing on the wire
  always @(posedge clk) begin
    oe_d <= oe;
    whi <= oe ? whi + 1 : 0;
    wgap <= wgap + 1;
    quiet <= line ? quiet + 1 : 0;
    if (oe === 1'b1) cmp(32'(lo), 32'h0);
    if (oe && !oe_d) begin
      if (armed) rng(wgap, int'(CYC_P), int'(CYC_P));
      else rng(quiet, 4750, 23750);
      armed <= 1'b1;
      wgap <= 1;
    end else if (!busy) begin
      armed <= 1'b0;
    end
    if (!oe && oe_d) cmp(32'((whi >= ONE_MIN_CYC && whi <= ONE_MAX_CYC) ||
      (whi >= ZERO_MIN_CYC && whi <= ZERO_MAX_CYC)), 32'h1);
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    req = 1'b0;
    cmd = '0;
    st = 1'b0;
    brk = 1'b0;
    rd = 1'b0;
    nb = 5'h00;
    word = 16'h0000;
    void'($urandom(32'h1b0f));
    a = ADDR_W'($urandom);
    b = a ^ 7'h55;
    d = DATA_W'($urandom);
    e = ~d;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp(32'({oe, busy, ack, sw_wr}), 32'h0);
    host_op(1'b0, 5'h01, 16'h0000, 1'b0);
    host_op(1'b1, 5'h00, 16'h0000, 1'b0);
    exp_q.push_back({1'b0, a, d});
    host_op(1'b0, 5'h10, {d, 1'b1, a}, 1'b0);
    exp_q.push_back({8'h00, d});
    tw(1'b0, a, 8'h00);
    tw(1'b1, b, e);
    exp_q.push_back({8'h00, e});
    tw(1'b0, b, 8'h00);
    exp_q.push_back({8'h00, e});
    host_op(1'b0, 5'h08, {8'h00, 1'b0, b}, 1'b1);
    cmp(32'(exp_q.size()), 32'h0);
    summarize();
  end

  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule // gsl_link_tb
